// ==== fssp_pkg.sv ====
// Constants for the host-side controller of a parallel NOR flash
// Assumes a 16-bit data bus and 21-bit word address on the flash side
// Notes on behaviour
// - During suspend, read only outside suspended sector; host reads any address, and a read inside it returns status
// - Suspend and resume are single writes
// - User half written by four-cycle sequence
// - Lock sequence sends lock data bit zero
// - Exit identification after protection register reads
// - Query mode held until exit command
// - Reread poll bit when timeout seen
// - Resample toggle bit when timeout seen
// - Identification exit uses data F0
package fssp_pkg;
  localparam int CLK_MHZ          = 200;
  localparam int SUSPEND_US       = 10;
  localparam int SUSPEND_CYC      = SUSPEND_US * CLK_MHZ;
  localparam int POWERON_MS       = 10;
  localparam int POWERON_CYC      = POWERON_MS * 1000 * CLK_MHZ;
  localparam int WE_PULSE_NS      = 40;
  localparam int WE_PULSE_CYC     = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_ACCESS_NS     = 80;
  localparam int RD_ACCESS_CYC    = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W            = 24;
  localparam int AW               = 21;
  localparam int DW               = 16;

  localparam logic [11:0] ADR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADR_UNLOCK2 = 12'hAAA;
  localparam logic [11:0] ADR_QUERY   = 12'h055;
  localparam logic [11:0] ADR_LOCKST  = 12'h080;
  localparam logic [11:0] ADR_ANY     = 12'h000;
  localparam logic [7:0]  DAT_UNLOCK1 = 8'hAA;
  localparam logic [7:0]  DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0]  DAT_PROTPGM = 8'hC0;
  localparam logic [7:0]  DAT_IDENTRY = 8'h90;
  localparam logic [7:0]  DAT_IDEXIT  = 8'hF0;
  localparam logic [7:0]  DAT_SUSPEND = 8'hB0;
  localparam logic [7:0]  DAT_RESUME  = 8'h30;
  localparam logic [7:0]  DAT_QUERY   = 8'h98;
  localparam logic [7:0]  DAT_LOCK    = 8'h00;
  localparam int LOCK_BIT     = 1;
  localparam int POLL_BIT     = 7;
  localparam int TOGGLE_BIT   = 6;
  localparam int TIMEOUT_BIT  = 5;
  localparam int SUPPLY_BIT   = 3;

  typedef enum logic [3:0] {
    OP_READ, OP_SUSPEND, OP_RESUME, OP_PROT_PGM, OP_PROT_LOCK,
    OP_ID_ENTRY, OP_ID_EXIT, OP_QUERY, OP_LOCK_STATUS, OP_STATUS
  } fssp_op_e;
endpackage : fssp_pkg

// ==== fssp_seq_rom.sv ====
// Command sequence table: per operation and step gives address, data, last flag
// Assumes step indices below four; registered output one cycle after request
`timescale 1ns/100ps
module fssp_seq_rom (
  input  wire logic            clk_sys,
  input  wire logic [3:0]      op,
  input  wire logic [1:0]      step,
  input  wire logic [20:0]     user_addr,
  input  wire logic [15:0]     user_data,
  output logic      [20:0]     rom_addr,
  output logic      [15:0]     rom_data,
  output logic                 rom_last
);
  function automatic logic [11:0] unlock_adr(input logic [1:0] s);
    unlock_adr = s[0] ? fssp_pkg::ADR_UNLOCK2 : fssp_pkg::ADR_UNLOCK1;
  endfunction : unlock_adr

  function automatic logic [7:0] unlock_dat(input logic [1:0] s);
    unlock_dat = s[0] ? fssp_pkg::DAT_UNLOCK2 : fssp_pkg::DAT_UNLOCK1;
  endfunction : unlock_dat

  logic [20:0] a;
  logic [15:0] d;
  logic        l;

  always_comb begin
    a = {9'h000, unlock_adr(step)};
    d = {8'h00, unlock_dat(step)};
    l = 1'b0;
    case (fssp_pkg::fssp_op_e'(op))
      fssp_pkg::OP_SUSPEND: begin
        a = {9'h000, fssp_pkg::ADR_ANY};
        d = {8'h00, fssp_pkg::DAT_SUSPEND};
        l = 1'b1;
      end
      fssp_pkg::OP_RESUME: begin
        a = {9'h000, fssp_pkg::ADR_ANY};
        d = {8'h00, fssp_pkg::DAT_RESUME};
        l = 1'b1;
      end
      fssp_pkg::OP_ID_EXIT: begin
        a = {9'h000, fssp_pkg::ADR_ANY};
        d = {8'h00, fssp_pkg::DAT_IDEXIT};
        l = 1'b1;
      end
      fssp_pkg::OP_QUERY: begin
        a = {9'h000, fssp_pkg::ADR_QUERY};
        d = {8'h00, fssp_pkg::DAT_QUERY};
        l = 1'b1;
      end
      fssp_pkg::OP_ID_ENTRY: begin
        if (step == 2'd2) begin
          a = {9'h000, fssp_pkg::ADR_UNLOCK1};
          d = {8'h00, fssp_pkg::DAT_IDENTRY};
          l = 1'b1;
        end
      end
      fssp_pkg::OP_PROT_PGM: begin
        if (step == 2'd2) begin
          a = {9'h000, fssp_pkg::ADR_UNLOCK1};
          d = {8'h00, fssp_pkg::DAT_PROTPGM};
        end else if (step == 2'd3) begin
          a = user_addr;
          d = user_data;
          l = 1'b1;
        end
      end
      fssp_pkg::OP_PROT_LOCK: begin
        if (step == 2'd2) begin
          a = {9'h000, fssp_pkg::ADR_UNLOCK1};
          d = {8'h00, fssp_pkg::DAT_PROTPGM};
        end else if (step == 2'd3) begin
          a = {9'h000, fssp_pkg::ADR_LOCKST};
          d = {8'h00, fssp_pkg::DAT_LOCK};
          l = 1'b1;
        end
      end
      default: begin
        l = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    rom_addr <= a;
    rom_data <= d;
    rom_last <= l;
  end
endmodule : fssp_seq_rom

// ==== fssp_host.sv ====
// Host controller driving the flash pins; takes one operation at a time
// Assumes flash pins are synchronous to clk_sys; ready_busy_n is the wired line
`timescale 1ns/100ps
module fssp_host #(
  parameter int POWERON_CYC = fssp_pkg::POWERON_CYC
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            cmd_valid,
  input  wire logic [3:0]      cmd_op,
  input  wire logic [20:0]     cmd_addr,
  input  wire logic [15:0]     cmd_wdata,
  output logic                 cmd_ready,
  output logic                 rsp_valid,
  output logic      [15:0]     rsp_rdata,
  output logic                 rsp_locked,
  output logic                 rsp_error,
  output logic                 in_id_mode,
  output logic                 in_query_mode,
  output logic                 prog_suspended,
  output logic                 flash_busy,
  output logic      [20:0]     flash_addr,
  output logic      [15:0]     flash_dq_o,
  output logic                 flash_dq_oe,
  input  wire logic [15:0]     flash_dq_i,
  output logic                 flash_ce_n,
  output logic                 flash_oe_n,
  output logic                 flash_we_n,
  input  wire logic            ready_busy_n
);
  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_FETCH, ST_WSETUP, ST_WPULSE, ST_RD, ST_WAIT, ST_CHECK
  } fssp_state_e;

  typedef struct packed {
    fssp_state_e state;
    logic [3:0]  op;
    logic [1:0]  step;
    logic [20:0] uaddr;
    logic [15:0] udata;
    logic [31:0] cnt;
    logic        rsp_valid;
    logic [15:0] rdata;
    logic        locked;
    logic        err;
    logic        id_mode;
    logic        query_mode;
    logic        susp;
    logic [20:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reread;
  } fssp_st_s;

  fssp_st_s    st_ff;
  fssp_st_s    nxt_st;
  logic [20:0] rom_addr;
  logic [15:0] rom_data;
  logic        rom_last;

  fssp_seq_rom fssp_seq_rom_i (
    .clk_sys   (clk_sys),
    .op        (st_ff.op),
    .step      (st_ff.step),
    .user_addr (st_ff.uaddr),
    .user_data (st_ff.udata),
    .rom_addr  (rom_addr),
    .rom_data  (rom_data),
    .rom_last  (rom_last)
  );

  function automatic logic is_read_op(input logic [3:0] op);
    is_read_op = (op == 4'(fssp_pkg::OP_READ)) || (op == 4'(fssp_pkg::OP_LOCK_STATUS))
              || (op == 4'(fssp_pkg::OP_STATUS));
  endfunction : is_read_op

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    case (st_ff.state)
      ST_POWERUP: begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (st_ff.cnt >= 32'(POWERON_CYC - 1)) begin
          nxt_st.state = ST_IDLE;
          nxt_st.cnt   = 32'h0;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          nxt_st.op     = cmd_op;
          nxt_st.uaddr  = cmd_addr;
          nxt_st.udata  = cmd_wdata;
          nxt_st.step   = 2'd0;
          nxt_st.err    = 1'b0;
          nxt_st.reread = 1'b0;
          nxt_st.cnt    = 32'h0;
          if (is_read_op(cmd_op)) begin
            nxt_st.addr = (cmd_op == 4'(fssp_pkg::OP_LOCK_STATUS))
                          ? {9'h000, fssp_pkg::ADR_LOCKST} : cmd_addr;
            nxt_st.ce_n  = 1'b0;
            nxt_st.oe_n  = 1'b0;
            nxt_st.dq_oe = 1'b0;
            nxt_st.state = ST_RD;
          end else begin
            nxt_st.state = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        nxt_st.state = ST_WSETUP;
      end
      ST_WSETUP: begin
        nxt_st.addr  = rom_addr;
        nxt_st.dq    = rom_data;
        nxt_st.dq_oe = 1'b1;
        nxt_st.oe_n  = 1'b1;
        nxt_st.ce_n  = 1'b0;
        nxt_st.we_n  = 1'b0;
        nxt_st.cnt   = 32'h0;
        nxt_st.state = ST_WPULSE;
      end
      ST_WPULSE: begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (st_ff.cnt >= 32'(fssp_pkg::WE_PULSE_CYC - 1)) begin
          nxt_st.we_n = 1'b1;
          nxt_st.ce_n = 1'b1;
          nxt_st.cnt  = 32'h0;
          if (rom_last) begin
            nxt_st.dq_oe = 1'b0;
            case (fssp_pkg::fssp_op_e'(st_ff.op))
              fssp_pkg::OP_SUSPEND: begin
                nxt_st.susp  = 1'b1;
                nxt_st.state = ST_WAIT;
              end
              fssp_pkg::OP_RESUME: begin
                nxt_st.susp      = 1'b0;
                nxt_st.rsp_valid = 1'b1;
                nxt_st.state     = ST_IDLE;
              end
              fssp_pkg::OP_ID_ENTRY: begin
                nxt_st.id_mode   = 1'b1;
                nxt_st.rsp_valid = 1'b1;
                nxt_st.state     = ST_IDLE;
              end
              fssp_pkg::OP_ID_EXIT: begin
                nxt_st.id_mode    = 1'b0;
                nxt_st.query_mode = 1'b0;
                nxt_st.rsp_valid  = 1'b1;
                nxt_st.state      = ST_IDLE;
              end
              fssp_pkg::OP_QUERY: begin
                nxt_st.query_mode = 1'b1;
                nxt_st.rsp_valid  = 1'b1;
                nxt_st.state      = ST_IDLE;
              end
              fssp_pkg::OP_PROT_PGM, fssp_pkg::OP_PROT_LOCK: begin
                nxt_st.state = ST_WAIT;
              end
              default: begin
                nxt_st.rsp_valid = 1'b1;
                nxt_st.state     = ST_IDLE;
              end
            endcase
          end else begin
            nxt_st.step  = st_ff.step + 2'd1;
            nxt_st.state = ST_FETCH;
          end
        end
      end
      ST_WAIT: begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (st_ff.op == 4'(fssp_pkg::OP_SUSPEND)) begin
          if (st_ff.cnt >= 32'(fssp_pkg::SUSPEND_CYC - 1)) begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.state     = ST_IDLE;
          end
        end else if (st_ff.cnt >= 32'h2 && ready_busy_n) begin
          nxt_st.addr  = st_ff.uaddr;
          nxt_st.ce_n  = 1'b0;
          nxt_st.oe_n  = 1'b0;
          nxt_st.cnt   = 32'h0;
          nxt_st.state = ST_RD;
        end
      end
      ST_RD: begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (st_ff.cnt >= 32'(fssp_pkg::RD_ACCESS_CYC - 1)) begin
          nxt_st.ce_n  = 1'b1;
          nxt_st.oe_n  = 1'b1;
          nxt_st.rdata = flash_dq_i;
          nxt_st.cnt   = 32'h0;
          nxt_st.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        nxt_st.state     = ST_IDLE;
        nxt_st.rsp_valid = 1'b1;
        if (st_ff.op == 4'(fssp_pkg::OP_LOCK_STATUS)) begin
          nxt_st.locked = ~st_ff.rdata[fssp_pkg::LOCK_BIT];
        end else if (!is_read_op(st_ff.op)) begin
          nxt_st.err = st_ff.rdata[fssp_pkg::TIMEOUT_BIT] | st_ff.rdata[fssp_pkg::SUPPLY_BIT];
          if (st_ff.rdata[fssp_pkg::TIMEOUT_BIT] && !st_ff.reread) begin
            nxt_st.reread    = 1'b1;
            nxt_st.rsp_valid = 1'b0;
            nxt_st.ce_n      = 1'b0;
            nxt_st.oe_n      = 1'b0;
            nxt_st.state     = ST_RD;
          end
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.state <= ST_POWERUP;
      st_ff.ce_n  <= 1'b1;
      st_ff.oe_n  <= 1'b1;
      st_ff.we_n  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_ready      = (st_ff.state == ST_IDLE);
  assign rsp_valid      = st_ff.rsp_valid;
  assign rsp_rdata      = st_ff.rdata;
  assign rsp_locked     = st_ff.locked;
  assign rsp_error      = st_ff.err;
  assign in_id_mode     = st_ff.id_mode;
  assign in_query_mode  = st_ff.query_mode;
  assign prog_suspended = st_ff.susp;
  assign flash_busy     = st_ff.state == ST_WAIT;
  assign flash_addr     = st_ff.addr;
  assign flash_dq_o     = st_ff.dq;
  assign flash_dq_oe    = st_ff.dq_oe;
  assign flash_ce_n     = st_ff.ce_n;
  assign flash_oe_n     = st_ff.oe_n;
  assign flash_we_n     = st_ff.we_n;
endmodule : fssp_host

// ==== fssp_host_asserts.sv ====
// Port assertions for the flash host controller
// Bound into fssp_host; sees its ports only
`timescale 1ns/100ps
module fssp_host_asserts #(
  parameter int POWERON_CYC = 20
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [3:0]  cmd_op,
  input wire logic        rsp_valid,
  input wire logic        in_query_mode,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n
);
  wire  tk = cmd_valid && cmd_ready;
  int   pon_ff;
  int   sus_ff;
  logic sp_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pon_ff <= 0;
      sus_ff <= 0;
      sp_ff <= 1'b0;
    end else begin
      if (pon_ff < POWERON_CYC) pon_ff <= pon_ff + 1;
      if (tk) sp_ff <= (cmd_op == fssp_pkg::OP_SUSPEND);
      sus_ff <= tk ? 0 : sus_ff + 1;
    end
  end
  ////////////////////////////////////////
  we_strobe_a: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe)
    else $error("bad levels in write");
  poweron_wait_a: assert property (!flash_we_n |-> pon_ff >= POWERON_CYC)
    else $error("write too soon");
  suspend_wait_a: assert property (rsp_valid && sp_ff |-> sus_ff >= fssp_pkg::SUSPEND_CYC)
    else $error("suspend answered early");
  suspend_code_a: assert property (tk && cmd_op == fssp_pkg::OP_SUSPEND
    |-> ##[1:20] (!flash_we_n && flash_dq_o[7:0] == 8'hB0)) else $error("no suspend write");
  resume_code_a: assert property (tk && cmd_op == fssp_pkg::OP_RESUME
    |-> ##[1:20] (!flash_we_n && flash_dq_o[7:0] == 8'h30)) else $error("no resume write");
  query_entry_a: assert property (tk && cmd_op == fssp_pkg::OP_QUERY
    |-> ##[1:20] (!flash_we_n && flash_dq_o[7:0] == 8'h98 && flash_addr[11:0] == 12'h055))
    else $error("no query write");
  idexit_code_a: assert property (tk && cmd_op == fssp_pkg::OP_ID_EXIT
    |-> ##[1:20] (!flash_we_n && flash_dq_o[7:0] == 8'hF0)) else $error("no exit write");
  lock_data_a: assert property (tk && cmd_op == fssp_pkg::OP_PROT_LOCK
    |-> ##[1:80] (!flash_we_n && flash_addr[11:0] == 12'h080 && !flash_dq_o[1]))
    else $error("no lock write");
  query_exit_a: assert property (tk && cmd_op == fssp_pkg::OP_ID_EXIT
    |-> ##[1:40] !in_query_mode) else $error("query mode kept");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
endmodule : fssp_host_asserts
bind fssp_host fssp_host_asserts #(.POWERON_CYC(POWERON_CYC)) fssp_host_asserts_i (.*);

// ==== fssp_flash_model.sv ====
// Behavioural flash device: command decode, protection register, modes
// Assumes pins change on clk_sys; rb_pull high pulls the shared line low
`timescale 1ns/100ps
module fssp_flash_model #(
  parameter int          PON_CYC   = 18,
  parameter int          BUSY_CYC  = 200,
  parameter logic [15:0] FACT_WORD = 16'hC3A5  // Arbitrary factory value
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  output logic     [15:0] flash_dq_i,
  output logic            rb_pull
);
  logic [15:0] pr [0:15];
  logic [15:0] lastv;
  logic        we_q, id, qry, lck, sus, err, srd, etog;
  logic [8:0]  ssec;
  logic [1:0]  st;
  int          pon, bsy;
  wire [11:0]  a = flash_addr[11:0];
  wire [7:0]   d = flash_dq_o[7:0];
  assign rb_pull = bsy > 0;
  always_ff @(posedge clk_sys) begin
    we_q <= flash_we_n;
    etog <= etog ^ !flash_oe_n;
    if (!flash_oe_n) lastv <= flash_dq_i;
    if (bsy > 0) bsy <= bsy - 1;
    if (rst) begin
      {id, qry, lck, sus, err, srd, st, etog, ssec} <= '0;
      pon <= 0;
      bsy <= 0;
      for (int i = 0; i < 16; i++) pr[i] <= (i > 0 && i < 5) ? FACT_WORD : 16'hFFFF;
    end else if (pon < PON_CYC) pon <= pon + 1;
    else if (!flash_we_n && we_q && !flash_ce_n && flash_oe_n) begin
      srd <= 1'b0;
      if (st == 2'd3) begin
        st <= 2'd0;
        srd <= 1'b1;
        bsy <= BUSY_CYC;
        ssec <= flash_addr[20:12];
        if (a == 12'h080) lck <= lck | !flash_dq_o[1];
        else if (a > 12'h084 && a < 12'h089 && !lck) pr[a[3:0]] <= flash_dq_o;
        else err <= 1'b1;
      end else if (st == 2'd2) begin
        st <= (a == 12'h555 && d == 8'hC0) ? 2'd3 : 2'd0;
        if (a == 12'h555 && d == 8'h90) id <= 1'b1;
      end else if (st == 2'd1) st <= (a == 12'hAAA && d == 8'h55) ? 2'd2 : 2'd0;
      else if (a == 12'h555 && d == 8'hAA) st <= 2'd1;
      else if (d == 8'hB0) sus <= 1'b1;
      else if (d == 8'h30) sus <= 1'b0;
      else if (d == 8'h98 && a == 12'h055) qry <= 1'b1;
      else {id, qry, err} <= '0;
    end
  end
  always_comb begin
    if (flash_ce_n || flash_oe_n) flash_dq_i = ~lastv;
    else if (sus && flash_addr[20:12] == ssec) flash_dq_i = {8'h00, 2'b11, 3'b000, etog, 2'b00};
    else if (srd) flash_dq_i = {8'h00, 2'b10, err, 5'h00};
    else if (qry) flash_dq_i = 16'h0051;
    else if (id && a == 12'h080) flash_dq_i = {14'h3FFF, !lck, 1'b1};
    else if (id && a > 12'h080 && a < 12'h089) flash_dq_i = pr[a[3:0]];
    else flash_dq_i = flash_addr[15:0] ^ 16'h5A5A;
  end
endmodule : fssp_flash_model

// ==== fssp_host_tb.sv ====
// Self-checking bench for the flash host controller
// Uses the behavioural flash model as the far side
`timescale 1ns/100ps
module fssp_host_tb;
  localparam int          PON  = 20;
  localparam logic [15:0] FACT = 16'hC3A5;
  logic        clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
  logic [3:0]  cmd_op = 4'h0;
  logic [20:0] cmd_addr = 21'h0, flash_addr;
  logic [15:0] cmd_wdata = 16'h0, rsp_rdata, flash_dq_o, flash_dq_i;
  logic        cmd_ready, rsp_valid, rsp_locked, rsp_error, in_id_mode, in_query_mode;
  logic        prog_suspended, flash_busy, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, rb_pull;
  wire         ready_busy_n = !rb_pull;
  int          error_cnt = 0, cmp_count = 0, lat = 0, busy_cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  fssp_host #(.POWERON_CYC(PON)) fssp_host_i (.*);
  fssp_flash_model #(.PON_CYC(PON - 2), .FACT_WORD(FACT)) fssp_flash_model_i (.*);
  ////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic tick();
    @(posedge clk_sys);
    #1;
    lat++;
    if (flash_busy === 1'b1) busy_cyc++;
    if (lat > 5000) begin
      error_cnt++;
      complete_run();
    end
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input fssp_pkg::fssp_op_e op, input logic [20:0] ad = 21'h0,
                        input logic [15:0] wd = 16'h0);
    lat = 0;
    while (cmd_ready !== 1'b1) tick();
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1) tick();
  endtask : run_op
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    run_op(fssp_pkg::OP_READ, 21'h012345);
    chk(rsp_rdata, 16'h2345 ^ 16'h5A5A);
    $display("read test done");
    run_op(fssp_pkg::OP_ID_ENTRY);
    chk(in_id_mode, 1'b1);
    run_op(fssp_pkg::OP_LOCK_STATUS);
    chk(rsp_locked, 1'b0);
    run_op(fssp_pkg::OP_ID_EXIT);
    chk(in_id_mode, 1'b0);
    $display("lock status test done");
    run_op(fssp_pkg::OP_PROT_PGM, 21'h000086, 16'hBEEF);
    chk(rsp_error, 1'b0);
    chk(lat > 200, 1'b1);
    run_op(fssp_pkg::OP_PROT_PGM, 21'h000082, 16'h0000);
    chk(rsp_error, 1'b1);
    run_op(fssp_pkg::OP_STATUS, 21'h000082);
    chk(rsp_rdata & 16'h00E8, 16'h00A0);
    run_op(fssp_pkg::OP_ID_EXIT);
    run_op(fssp_pkg::OP_PROT_LOCK);
    chk(rsp_error, 1'b0);
    run_op(fssp_pkg::OP_ID_ENTRY);
    run_op(fssp_pkg::OP_LOCK_STATUS);
    chk(rsp_locked, 1'b1);
    run_op(fssp_pkg::OP_ID_EXIT);
    run_op(fssp_pkg::OP_PROT_PGM, 21'h000086, 16'h1234);
    chk(rsp_error, 1'b1);
    run_op(fssp_pkg::OP_ID_EXIT);
    run_op(fssp_pkg::OP_ID_ENTRY);
    run_op(fssp_pkg::OP_READ, 21'h000086);
    chk(rsp_rdata, 16'hBEEF);
    run_op(fssp_pkg::OP_READ, 21'h000082);
    chk(rsp_rdata, FACT);
    $display("protection register test done");
    run_op(fssp_pkg::OP_QUERY);
    chk(in_query_mode, 1'b1);
    run_op(fssp_pkg::OP_READ, 21'h000010);
    chk(rsp_rdata, 16'h0051);
    run_op(fssp_pkg::OP_ID_EXIT);
    chk(in_query_mode, 1'b0);
    run_op(fssp_pkg::OP_READ, 21'h000010);
    chk(rsp_rdata, 16'h0010 ^ 16'h5A5A);
    $display("query test done");
    busy_cyc = 0;
    run_op(fssp_pkg::OP_SUSPEND);
    chk(lat >= fssp_pkg::SUSPEND_CYC, 1'b1);
    chk(16'(busy_cyc), 16'(fssp_pkg::SUSPEND_CYC));
    chk(prog_suspended, 1'b1);
    run_op(fssp_pkg::OP_READ, 21'h1F0777);
    chk(rsp_rdata, 16'h0777 ^ 16'h5A5A);
    run_op(fssp_pkg::OP_READ, 21'h000100);
    chk(rsp_rdata & 16'h00E8, 16'h00C0);
    chk(ready_busy_n, 1'b1);
    run_op(fssp_pkg::OP_RESUME);
    chk(prog_suspended, 1'b0);
    $display("suspend test done");
    complete_run();
  end
endmodule : fssp_host_tb
